// >>> include/ssl_pkg.sv
package ssl_pkg;

    // Virtual stack window shared by the pointer and both limits.
    localparam logic [15:0] SSL_VIRT_BASE = 16'hf000;
    localparam logic [15:0] SSL_VIRT_TOP = 16'hfffe;
    localparam logic [15:0] SSL_PHYS_TOP = 16'hfbfe;
    localparam logic [15:0] SSL_LINEAR_TOP = 16'hfdfe;

    // Lower internal RAM limits for the linear option.
    localparam logic [15:0] SSL_LOW_1KB = 16'hfa00;
    localparam logic [15:0] SSL_LOW_2KB = 16'hf600;
    localparam logic [15:0] SSL_LOW_3KB = 16'hf200;

    // Reset values.
    localparam logic [15:0] SSL_RST_OVF = 16'hfa00;
    localparam logic [15:0] SSL_RST_UNF = 16'hfc00;
    localparam logic [15:0] SSL_RST_SP = 16'hfc00;
    localparam logic [2:0] SSL_RST_SIZE = 3'h0;

    // Size select codes.
    localparam logic [2:0] SSL_SIZE_256 = 3'h0;
    localparam logic [2:0] SSL_SIZE_128 = 3'h1;
    localparam logic [2:0] SSL_SIZE_64 = 3'h2;
    localparam logic [2:0] SSL_SIZE_32 = 3'h3;
    localparam logic [2:0] SSL_SIZE_512 = 3'h4;
    localparam logic [2:0] SSL_SIZE_LINEAR = 3'h7;

    // Bytes moved by one word push or pop.
    localparam logic [11:0] SSL_WORD_STEP = 12'h002;

    // Register byte offsets.
    localparam logic [4:0] SSL_OFF_SP = 5'h00;
    localparam logic [4:0] SSL_OFF_OVF = 5'h04;
    localparam logic [4:0] SSL_OFF_UNF = 5'h08;
    localparam logic [4:0] SSL_OFF_SIZE = 5'h0c;
    localparam logic [4:0] SSL_OFF_PHYS = 5'h10;
    localparam logic [4:0] SSL_OFF_STATUS = 5'h14;

    // Field positions.
    localparam int SSL_SIZE_LSB = 0;
    localparam int SSL_STAT_BAD_BIT = 0;
    localparam int SSL_STAT_OVF_BIT = 1;
    localparam int SSL_STAT_UNF_BIT = 2;

    typedef enum logic [1:0] {
        SSL_OP_NONE,
        SSL_OP_DEC,
        SSL_OP_INC,
        SSL_OP_MOVE
    } ssl_op_type;

    // Mask of the stack-pointer bits that reach the physical address.
    function automatic logic [15:0] ssl_sig_mask(input logic [2:0] size);
        logic [15:0] m;
        m = 16'h01ff;
        unique case (size)
            SSL_SIZE_128: m = 16'h00ff;
            SSL_SIZE_64: m = 16'h007f;
            SSL_SIZE_32: m = 16'h003f;
            SSL_SIZE_512: m = 16'h03ff;
            SSL_SIZE_LINEAR: m = 16'h0fff;
            default: m = 16'h01ff;
        endcase
        return m;
    endfunction

    // Pointer value forced into the virtual window on an even address.
    function automatic logic [15:0] ssl_virt(input logic [11:0] low);
        return {SSL_VIRT_BASE[15:12], low[11:1], 1'b0};
    endfunction

endpackage

// >>> include/ssl_map_if.sv
`timescale 1ns/1ps
interface ssl_map_if;
    logic [15:0] sp_nxt;
    logic [2:0] size_nxt;
    logic [15:0] phys;
    logic [15:0] low_limit;
    logic size_bad;

    modport core (output sp_nxt, output size_nxt, input phys, input low_limit, input size_bad);
    modport mapper (input sp_nxt, input size_nxt, output phys, output low_limit, output size_bad);
endinterface

// >>> verilog/ssl_map.sv
`timescale 1ns/1ps
module ssl_map
    import ssl_pkg::*;
#(
    parameter int IRAM_KB = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Mapping link to the stack core.
    ssl_map_if.mapper map
);

    if (IRAM_KB < 1 || IRAM_KB > 3) begin : g_bad_iram
        $error("IRAM_KB must be 1, 2 or 3");
    end

    localparam logic [15:0] LOW_LIMIT = (IRAM_KB == 1) ? SSL_LOW_1KB :
                                        (IRAM_KB == 2) ? SSL_LOW_2KB : SSL_LOW_3KB;

    logic [15:0] phys_r;
    logic [15:0] phys_nxt;
    logic [15:0] mask;

    always_comb begin
        mask = ssl_sig_mask(map.size_nxt);
        if (map.size_nxt == SSL_SIZE_LINEAR) begin
            phys_nxt = map.sp_nxt;
        end else begin
            // Upper bits come from the top of the area, so wrap-around is free.
            phys_nxt = (SSL_PHYS_TOP & ~mask) | (map.sp_nxt & mask);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phys_r <= SSL_RST_SP;
        end else begin
            phys_r <= phys_nxt;
        end
    end

    assign map.phys = phys_r;
    assign map.low_limit = LOW_LIMIT;
    // The 512 word area reaches below a 1 KB RAM; reserved codes also count as bad.
    assign map.size_bad = (map.size_nxt == 3'h5) || (map.size_nxt == 3'h6) ||
                          (map.size_nxt == SSL_SIZE_512 && IRAM_KB == 1);

    a_phys_circular: assert property (@(posedge clk) disable iff (rst)
        (map.size_nxt != SSL_SIZE_LINEAR) |=>
        (phys_r[15:12] == 4'hf) && (phys_r <= SSL_PHYS_TOP) &&
        ((phys_r & ssl_sig_mask($past(map.size_nxt))) ==
         ($past(map.sp_nxt) & ssl_sig_mask($past(map.size_nxt)))))
        else $error("physical address not formed from significant pointer bits");

    a_phys_linear: assert property (@(posedge clk) disable iff (rst)
        (map.size_nxt == SSL_SIZE_LINEAR) |=> (phys_r == $past(map.sp_nxt)))
        else $error("linear mode must not transform the address");

    a_wrap_256: assert property (@(posedge clk) disable iff (rst)
        (map.size_nxt == SSL_SIZE_256 && map.sp_nxt == 16'hf7fe) |=> (phys_r == 16'hfbfe))
        else $error("push below bottom did not wrap to top of area");

endmodule // ssl_map

// >>> verilog/ssl_top.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Pointer moves down on every push and up on every pop.
// - Stack entries are whole 16-bit words; byte steps are rounded to words.
// - Pointer bit zero always reads zero whatever is written.
// - Decrement by call, push or subtract traps when pointer below overflow limit.
// - Increment by return, pop or add traps when pointer above underflow limit.
// - A plain move into the pointer never compares and never traps.
// - Pointer and both limits span the window F000 to FFFE.
// - Size code picks 256, 128, 64, 32 or 512 words ending at FBFE.
// - Significant pointer bits follow the size code, up to 11..0 linear.
// - Circular address joins pointer bits with upper bits of FBFE.
// - Code 111 disables transformation; linear stack up to FDFE, no wrap; the pointer here still runs up to FFFE and wraps inside F000 to FFFE.
// - Linear lower RAM limit is FA00, F600 or F200 by RAM size.
// - Reset gives overflow FA00, underflow FC00, pointer FC00, size 000.
// - Word push subtracts two; below the bottom the address wraps to top.
module ssl_top
    import ssl_pkg::*;
#(
    parameter int IRAM_KB = 2
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    // Register port.
    input wire logic [4:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    // Core stack operations.
    input wire logic CORE_DEC,
    input wire logic CORE_INC,
    input wire logic [11:0] CORE_DELTA,
    input wire logic CORE_MOVE,
    input wire logic [15:0] CORE_MOVE_DATA,
    // Stack state and traps toward the core.
    output logic [15:0] STACK_POINTER,
    output logic [15:0] STACK_PHYS_ADDR,
    output logic OVERFLOW_TRAP,
    output logic UNDERFLOW_TRAP
);

    ssl_map_if map ();

    ssl_map #(
        .IRAM_KB(IRAM_KB)
    ) u_map (
        .clk(CLK),
        .rst(SYS_RST),
        .map(map)
    );

    logic [15:0] sp_r;
    logic [15:0] sp_nxt;
    logic [15:0] ovf_r;
    logic [15:0] ovf_nxt;
    logic [15:0] unf_r;
    logic [15:0] unf_nxt;
    logic [2:0] size_r;
    logic [2:0] size_nxt;
    logic ovf_trap_r;
    logic ovf_trap_nxt;
    logic unf_trap_r;
    logic unf_trap_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [11:0] step;
    ssl_op_type op;

    // Core actions win over a software write in the same cycle, so that a
    // running push is never lost to a register access.
    always_comb begin
        if (CORE_MOVE) begin
            op = SSL_OP_MOVE;
        end else if (CORE_DEC) begin
            op = SSL_OP_DEC;
        end else if (CORE_INC) begin
            op = SSL_OP_INC;
        end else begin
            op = SSL_OP_NONE;
        end
    end

    always_comb begin
        step = {CORE_DELTA[11:1], 1'b0};
        sp_nxt = sp_r;
        ovf_nxt = ovf_r;
        unf_nxt = unf_r;
        size_nxt = size_r;
        ovf_trap_nxt = 1'b0;
        unf_trap_nxt = 1'b0;
        if (REG_WR) begin
            unique case (REG_ADDR)
                // A software write is a plain load and is not checked.
                SSL_OFF_SP: sp_nxt = ssl_virt(REG_WDATA[11:0]);
                SSL_OFF_OVF: ovf_nxt = ssl_virt(REG_WDATA[11:0]);
                SSL_OFF_UNF: unf_nxt = ssl_virt(REG_WDATA[11:0]);
                // Reserved codes are stored as written; the status flag shows them.
                SSL_OFF_SIZE: size_nxt = REG_WDATA[SSL_SIZE_LSB +: 3];
                default: ;
            endcase
        end
        unique case (op)
            SSL_OP_MOVE: begin
                sp_nxt = ssl_virt(CORE_MOVE_DATA[11:0]);
            end
            SSL_OP_DEC: begin
                sp_nxt = ssl_virt(sp_r[11:0] - step);
                ovf_trap_nxt = (ssl_virt(sp_r[11:0] - step) < ovf_nxt);
            end
            SSL_OP_INC: begin
                sp_nxt = ssl_virt(sp_r[11:0] + step);
                unf_trap_nxt = (ssl_virt(sp_r[11:0] + step) > unf_nxt);
            end
            SSL_OP_NONE: ;
        endcase
    end

    // The read data answer one cycle after the strobe and read zero otherwise.
    always_comb begin
        rdata_nxt = 16'h0000;
        if (REG_RD) begin
            unique case (REG_ADDR)
                SSL_OFF_SP: rdata_nxt = sp_r;
                SSL_OFF_OVF: rdata_nxt = ovf_r;
                SSL_OFF_UNF: rdata_nxt = unf_r;
                SSL_OFF_SIZE: rdata_nxt = {13'h0000, size_r};
                SSL_OFF_PHYS: rdata_nxt = map.phys;
                SSL_OFF_STATUS: begin
                    rdata_nxt[SSL_STAT_BAD_BIT] = map.size_bad;
                    rdata_nxt[SSL_STAT_OVF_BIT] = (sp_r < ovf_r);
                    rdata_nxt[SSL_STAT_UNF_BIT] = (sp_r > unf_r);
                end
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sp_r <= SSL_RST_SP;
            ovf_r <= SSL_RST_OVF;
            unf_r <= SSL_RST_UNF;
            size_r <= SSL_RST_SIZE;
            ovf_trap_r <= 1'b0;
            unf_trap_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            sp_r <= sp_nxt;
            ovf_r <= ovf_nxt;
            unf_r <= unf_nxt;
            size_r <= size_nxt;
            ovf_trap_r <= ovf_trap_nxt;
            unf_trap_r <= unf_trap_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // The mapper works on the next values so the physical address changes with the pointer.
    assign map.sp_nxt = sp_nxt;
    assign map.size_nxt = size_nxt;

    assign STACK_POINTER = sp_r;
    assign STACK_PHYS_ADDR = map.phys;
    assign OVERFLOW_TRAP = ovf_trap_r;
    assign UNDERFLOW_TRAP = unf_trap_r;
    assign REG_RDATA = rdata_r;

    a_sp_even_window: assert property (@(posedge CLK) disable iff (SYS_RST)
        (sp_r[0] == 1'b0) && (sp_r[15:12] == 4'hf) && (ovf_r[15:12] == 4'hf) &&
        (unf_r[15:12] == 4'hf))
        else $error("pointer or limit left the even virtual window");

    a_push_moves_down: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CORE_DEC && !CORE_MOVE && CORE_DELTA == SSL_WORD_STEP) |=>
        (sp_r[11:0] == $past(sp_r[11:0]) - SSL_WORD_STEP))
        else $error("word push did not lower the pointer by two");

    a_pop_moves_up: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CORE_INC && !CORE_MOVE && !CORE_DEC && CORE_DELTA == SSL_WORD_STEP) |=>
        (sp_r[11:0] == $past(sp_r[11:0]) + SSL_WORD_STEP))
        else $error("word pop did not raise the pointer by two");

    a_ovf_trap_cause: assert property (@(posedge CLK) disable iff (SYS_RST)
        OVERFLOW_TRAP |-> ($past(CORE_DEC) && !$past(CORE_MOVE) && (sp_r < ovf_r)))
        else $error("overflow trap without a decrement below the limit");

    a_ovf_trap_taken: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CORE_DEC && !CORE_MOVE && !REG_WR && ssl_virt(sp_r[11:0] - step) < ovf_r) |=>
        OVERFLOW_TRAP)
        else $error("decrement below the limit raised no overflow trap");

    a_unf_trap_cause: assert property (@(posedge CLK) disable iff (SYS_RST)
        UNDERFLOW_TRAP |-> ($past(CORE_INC) && !$past(CORE_DEC) && !$past(CORE_MOVE) &&
        (sp_r > unf_r)))
        else $error("underflow trap without an increment above the limit");

    a_move_no_trap: assert property (@(posedge CLK) disable iff (SYS_RST)
        CORE_MOVE |=> !OVERFLOW_TRAP && !UNDERFLOW_TRAP &&
        (sp_r == {4'hf, $past(CORE_MOVE_DATA[11:1]), 1'b0}))
        else $error("plain move was checked or not loaded");

    a_trap_single: assert property (@(posedge CLK) disable iff (SYS_RST)
        (OVERFLOW_TRAP || UNDERFLOW_TRAP) |->
        ($past(sp_r) != sp_r || $past(CORE_DELTA[11:1]) == 11'h000)
        ##1 ((OVERFLOW_TRAP || UNDERFLOW_TRAP) -> $past(CORE_DEC || CORE_INC)))
        else $error("trap not tied to a pointer update cycle");

    a_reset_values: assert property (@(posedge CLK)
        $past(SYS_RST) |-> (sp_r == SSL_RST_SP) && (ovf_r == SSL_RST_OVF) &&
        (unf_r == SSL_RST_UNF) && (size_r == SSL_RST_SIZE) && !OVERFLOW_TRAP &&
        (STACK_PHYS_ADDR == SSL_RST_SP))
        else $error("reset values wrong");

    a_linear_low: assert property (@(posedge CLK) disable iff (SYS_RST)
        map.low_limit == ((IRAM_KB == 1) ? SSL_LOW_1KB :
                          (IRAM_KB == 2) ? SSL_LOW_2KB : SSL_LOW_3KB))
        else $error("linear lower RAM limit does not follow the RAM size");

endmodule // ssl_top

// >>> testbench/ssl_core_model.sv
`timescale 1ns/1ps
module ssl_core_model
    import ssl_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Stack operation requests toward the block.
    output logic dec,
    output logic inc,
    output logic [11:0] delta,
    output logic move,
    output logic [15:0] move_data
);
    initial begin
        dec = 1'b0;
        inc = 1'b0;
        move = 1'b0;
        delta = 12'h000;
        move_data = 16'h0000;
    end

    // One operation is a one-cycle pulse; operands are scrambled once released.
    task automatic issue(input ssl_op_type k, input logic [15:0] v);
        @(posedge clk);
        dec <= (k == SSL_OP_DEC);
        inc <= (k == SSL_OP_INC);
        move <= (k == SSL_OP_MOVE);
        delta <= v[11:0];
        move_data <= v;
        @(posedge clk);
        dec <= 1'b0;
        inc <= 1'b0;
        move <= 1'b0;
        delta <= ~v[11:0];
        move_data <= ~v;
    endtask
endmodule // ssl_core_model

// >>> testbench/ssl_top_tb.sv
`timescale 1ns/1ps
module ssl_top_tb
    import ssl_pkg::*;
;
    typedef struct packed {
        logic rd;
        logic [15:0] a;
        logic [15:0] b;
        logic ov;
        logic un;
    } ssl_exp_type;

    logic clk, sys_rst, reg_wr, reg_rd, c_dec, c_inc, c_move, ovf, unf, p_rd, p_op;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, c_data, sp, phys;
    logic [11:0] c_delta;
    logic [15:0] m_sp = 16'hfc00, m_ov = 16'hfa00, m_un = 16'hfc00;
    logic [2:0] m_sz = 3'h0;
    logic [31:0] seed = 32'h77343fbc;
    logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    ssl_exp_type exp_q[$];
    ssl_exp_type e;
    int num_errors = 0, n_checks = 0;

    ssl_core_model core (.clk(clk), .dec(c_dec), .inc(c_inc), .delta(c_delta), .move(c_move),
        .move_data(c_data));
    ssl_top #(.IRAM_KB(2)) DUT (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CORE_DEC(c_dec), .CORE_INC(c_inc), .CORE_DELTA(c_delta), .CORE_MOVE(c_move),
        .CORE_MOVE_DATA(c_data), .STACK_POINTER(sp), .STACK_PHYS_ADDR(phys),
        .OVERFLOW_TRAP(ovf), .UNDERFLOW_TRAP(unf));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] phys_of(input logic [15:0] s, input logic [2:0] z);
        logic [15:0] m;
        m = 16'h01ff;
        case (z)
            3'h1: m = 16'h00ff;
            3'h2: m = 16'h007f;
            3'h3: m = 16'h003f;
            3'h4: m = 16'h03ff;
            3'h7: m = 16'hffff;
            default: m = 16'h01ff;
        endcase
        return (s & m) | (SSL_PHYS_TOP & ~m);
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
        n_checks++;
        if (got !== want) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        if (a == SSL_OFF_SP) m_sp = {4'hf, d[11:1], 1'b0};
        if (a == SSL_OFF_OVF) m_ov = {4'hf, d[11:1], 1'b0};
        if (a == SSL_OFF_UNF) m_un = {4'hf, d[11:1], 1'b0};
        if (a == SSL_OFF_SIZE) m_sz = d[2:0];
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] d);
        exp_q.push_back('{1'b1, d, 16'h0000, 1'b0, 1'b0});
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic op(input ssl_op_type k, input logic [15:0] v);
        if (k == SSL_OP_MOVE) m_sp = {4'hf, v[11:1], 1'b0};
        if (k == SSL_OP_DEC) m_sp = {4'hf, m_sp[11:0] - {v[11:1], 1'b0}};
        if (k == SSL_OP_INC) m_sp = {4'hf, m_sp[11:0] + {v[11:1], 1'b0}};
        exp_q.push_back('{1'b0, m_sp, phys_of(m_sp, m_sz), (k == SSL_OP_DEC) && (m_sp < m_ov),
            (k == SSL_OP_INC) && (m_sp > m_un)});
        core.issue(k, v);
    endtask

    always @(posedge clk) begin
        p_rd <= reg_rd;
        p_op <= c_dec | c_inc | c_move;
    end

    // Results are looked at mid-cycle, after the launching edge has settled.
    always @(negedge clk) begin
        if ((p_rd === 1'b1 || p_op === 1'b1) && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e.rd) begin
                chk(reg_rdata, e.a, "read data");
            end else begin
                chk(sp, e.a, "pointer");
                chk(phys, e.b, "physical address");
                chk({15'h0000, ovf}, {15'h0000, e.ov}, "overflow trap");
                chk({15'h0000, unf}, {15'h0000, e.un}, "underflow trap");
            end
        end else begin
            chk({14'h0000, ovf, unf}, 16'h0000, "idle traps");
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        sys_rst = 1'b1;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        p_rd = 1'b0;
        p_op = 1'b0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(SSL_OFF_SP, 16'hfc00);
        rd(SSL_OFF_OVF, 16'hfa00);
        rd(SSL_OFF_UNF, 16'hfc00);
        rd(SSL_OFF_SIZE, 16'h0000);
        wr(SSL_OFF_PHYS, 16'hffff);
        rd(SSL_OFF_PHYS, phys_of(16'hfc00, 3'h0));
        rd(5'h1c, 16'h0000);
        $display("test reset values done");
        op(SSL_OP_MOVE, 16'hf802);
        op(SSL_OP_DEC, 16'h0002);
        op(SSL_OP_DEC, 16'h0002);
        op(SSL_OP_MOVE, 16'hfbfe);
        op(SSL_OP_INC, 16'h0005);
        op(SSL_OP_MOVE, 16'hf000);
        wr(SSL_OFF_OVF, 16'hfa0c);
        op(SSL_OP_MOVE, 16'hfa0e);
        op(SSL_OP_DEC, 16'h0002);
        op(SSL_OP_DEC, 16'h0003);
        $display("test traps and wrap done");
        wr(SSL_OFF_SP, 16'h0123);
        rd(SSL_OFF_SP, m_sp);
        wr(SSL_OFF_UNF, 16'h2fff);
        rd(SSL_OFF_UNF, m_un);
        $display("test pointer forcing done");
        // Reserved size codes are never written.
        foreach (codes[i]) begin
            wr(SSL_OFF_SIZE, {13'h0000, codes[i]});
            rd(SSL_OFF_SIZE, {13'h0000, codes[i]});
            for (int j = 0; j < 12; j++) begin
                seed = lfsr(seed);
                if (seed[4:2] == 3'h0) begin
                    wr(seed[5] ? SSL_OFF_OVF : SSL_OFF_UNF, seed[31:16]);
                end else if (seed[7:6] == 2'h0) begin
                    op(SSL_OP_MOVE, seed[31:16]);
                end else begin
                    op(seed[1] ? SSL_OP_DEC : SSL_OP_INC, {9'h000, seed[14:8]});
                end
            end
            rd(SSL_OFF_STATUS, {13'h0000, m_sp > m_un, m_sp < m_ov, 1'b0});
        end
        $display("test size codes done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        m_sp = SSL_RST_SP;
        m_ov = SSL_RST_OVF;
        m_un = SSL_RST_UNF;
        m_sz = SSL_RST_SIZE;
        rd(SSL_OFF_SP, m_sp);
        rd(SSL_OFF_OVF, m_ov);
        rd(SSL_OFF_UNF, m_un);
        rd(SSL_OFF_SIZE, {13'h0000, m_sz});
        op(SSL_OP_DEC, 16'h0002);
        $display("test reset in mid-run done");
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule // ssl_top_tb
